/* File: core/ieu_event_unit.sv */
// Two-wire bus slave event, flag, timeout and wake-up logic.
// Assumes a one-cycle register port and open-drain bus pins outside.
//
// How it works
// RQ1 - Interrupt line only asserts while the interrupt enable is set.
// RQ2 - Combined pending flag clears only when software writes one.
// RQ3 - Clock-low timeout flag feeds the interrupt; write one clears it.
// RQ4 - Clock-high data-low timeout interrupts only with its own enable.
// RQ5 - Low-power wake reports as address match, needs wake enable.
// RQ6 - Transfer done sets at ninth clock falling edge.
// RQ7 - With fast acknowledge, transfer done sets at eighth falling edge.
// RQ8 - Address flag sets on own address or enabled general call.
// RQ9 - Software reads direction bit and sets transmit mode to match.
// RQ10 - Address matching keeps running in low-power modes, wakes core.
// RQ11 - Arbitration lost flag sets on the listed bus conflicts.
// RQ12 - Arbitration lost flag clears only on a software write of one.
// RQ13 - Idle timeout flag rises and falls alone, never interrupts.
// RQ14 - Clock-high data-low timeout uses the idle timeout period.
// RQ15 - Input filter drops pulses shorter than programmed clock count.
// RQ16 - Software clears fast acknowledge before last received byte.
// RQ17 - Address match wakes the system, interrupt at match end.
// RQ18 - Software clears address flag after clock recovery.
// RQ19 - Master start sequence is a software duty.
// RQ20 - Software handles general call address in its service routine.
// RQ21 - Software drops data after first ten-bit address byte.
// RQ22 - Dummy data read resets the SMBus receiver state machine.
// RQ23 - Block is disabled after reset and never resets the core.
// RQ24 - Interrupt line is pending flag AND enable, held until cleared.
`timescale 1ns/1ps
`include "ieu_defines.svh"
module ieu_event_unit
  import ieu_pkg::*;
#(
  parameter int unsigned CLK_LOW_CYC =
    (`IEU_CLK_LOW_NS * `IEU_CLK_MHZ + 999) / 1000,
  parameter int unsigned HIGH_MAX_CYC = (`IEU_HIGH_MAX_NS * `IEU_CLK_MHZ)/1000
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic lowPowerMode,
  output logic irqReq,
  output logic wakeupReq
);
  ieu_lines_s line;
  ieu_lines_s prev_q;
  ieu_state_e state_q;
  logic [7:0] ctrl1_q, ctrl2_q, addr1_q, addr2_q, txData_q, rxData_q;
  logic [7:0] shift_q, txShift_q;
  logic [3:0] filt_q, bitCnt_q;
  logic tcf_q, aas_q, arbitration_lost_flag_q, srw_q, busy_q, irqPend_q;
  logic clto_q, idle_q, chdl_q, stretch_q;
  logic [31:0] lowCnt_q, highCnt_q, chdlCnt_q;

  // Saturating timeout counter step
  function automatic logic [31:0] tick(input logic on, input logic [31:0] c,
                                        input int unsigned tgt);
    if (!on) begin
      return 32'h0000_0000;
    end
    return (c == tgt) ? c : c + 32'h0000_0001;
  endfunction : tick

  //////////////////////////////////////////////////////////////////////////
  // Input synchronising and filtering
  ieu_glitch_filter #(.CW(4)) uFilter (
    .core_clk(core_clk),
    .resetn(resetn),
    .rawLines('{scl: sclIn, sda: sdaIn}),
    .limit(filt_q),
    .cleanLines(line)
  );

  logic modEn, irqEn, fast_ack_enable, sclRise, sclFall, startDet, stopDet;
  logic wrC1, wrSt, wrSm, rdData, addrMatch, endByte, endAck, dataPhase;
  logic evTcf, evAas, evArb, evClto, evChdl, rxReset;
  assign modEn = ctrl1_q[`IEU_C1_MODEN];
  assign irqEn = ctrl1_q[`IEU_C1_IRQEN];
  assign fast_ack_enable = ctrl1_q[`IEU_C1_FAST_ACK_ENABLE];
  assign sclRise = line.scl && !prev_q.scl;
  assign sclFall = !line.scl && prev_q.scl;
  assign startDet = line.scl && prev_q.scl && !line.sda && prev_q.sda;
  assign stopDet = line.scl && prev_q.scl && line.sda && !prev_q.sda;
  assign wrC1 = regWr && regAddr == `IEU_REG_CTRL1;
  assign wrSt = regWr && regAddr == `IEU_REG_STATUS;
  assign wrSm = regWr && regAddr == `IEU_REG_SMB;
  assign rdData = regRd && regAddr == `IEU_REG_DATA;
  // Own address, optional second address, or enabled general call [RQ8]
  assign addrMatch = (shift_q[7:1] == addr1_q[7:1]) ||
    (ctrl2_q[`IEU_C2_ADDR2EN] && shift_q[7:1] == addr2_q[7:1]) ||
    (ctrl2_q[`IEU_C2_GCEN] && shift_q == `IEU_GC_ADDR);
  assign endByte = sclFall && bitCnt_q == `IEU_LAST_BIT;
  assign endAck = sclFall && bitCnt_q == `IEU_ACK_BIT;
  assign dataPhase = state_q == ST_RX || state_q == ST_TX;
  // Dummy data read during a clock-low timeout restarts the receiver [RQ22]
  assign rxReset = rdData && clto_q;

  //////////////////////////////////////////////////////////////////////////
  // Event pulses
  // Byte done: ninth fall, or eighth under fast acknowledge [RQ6] [RQ7]
  assign evTcf = modEn && (fast_ack_enable ? endByte : endAck) && (dataPhase ||
    (state_q == ST_ADDR && (addrMatch || endAck)));
  // Match runs in every power mode; flag set at end of address [RQ10] [RQ17]
  assign evAas = modEn && state_q == ST_ADDR && endByte && addrMatch;
  assign evClto = modEn && !line.scl && lowCnt_q == CLK_LOW_CYC - 1;
  assign evChdl = modEn && line.scl && !line.sda &&
    chdlCnt_q == HIGH_MAX_CYC - 1;
  // Conflicts that lose the bus [RQ11]
  assign evArb = modEn && (
    (sclRise && !line.sda && !sdaOe && state_q == ST_TX &&
     bitCnt_q <= `IEU_LAST_BIT) ||
    (sclRise && !line.sda && !sdaOe && state_q == ST_RX &&
     bitCnt_q == `IEU_ACK_BIT) ||
    (wrC1 && regWrData[`IEU_C1_MST] && !ctrl1_q[`IEU_C1_MST] && busy_q) ||
    (wrC1 && regWrData[`IEU_C1_RSTA] && !ctrl1_q[`IEU_C1_MST]) ||
    (stopDet && ctrl1_q[`IEU_C1_MST]));

  //////////////////////////////////////////////////////////////////////////
  // Software registers; block starts disabled [RQ23]
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl1_q <= `IEU_RST_BYTE;
      ctrl2_q <= `IEU_RST_BYTE;
      addr1_q <= `IEU_RST_BYTE;
      addr2_q <= `IEU_RST_BYTE;
      txData_q <= `IEU_RST_BYTE;
      filt_q <= `IEU_FILT_RST;
    end else begin
      if (wrC1) begin
        ctrl1_q <= regWrData;
        ctrl1_q[`IEU_C1_RSTA] <= 1'b0;
        if (evArb) begin
          ctrl1_q[`IEU_C1_MST] <= 1'b0; // Lost bus drops master mode
        end
      end else if (evArb) begin
        ctrl1_q[`IEU_C1_MST] <= 1'b0;
      end
      if (regWr && regAddr == `IEU_REG_CTRL2) begin
        ctrl2_q <= regWrData;
      end
      if (regWr && regAddr == `IEU_REG_ADDR1) begin
        addr1_q <= regWrData;
      end
      if (regWr && regAddr == `IEU_REG_ADDR2) begin
        addr2_q <= regWrData;
      end
      if (regWr && regAddr == `IEU_REG_DATA) begin
        txData_q <= regWrData;
      end
      if (regWr && regAddr == `IEU_REG_FILT) begin
        filt_q <= regWrData[3:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Line history and bus busy
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= '{scl: 1'b1, sda: 1'b1};
      busy_q <= 1'b0;
    end else begin
      prev_q <= line;
      if (startDet) begin
        busy_q <= 1'b1;
      end else if (stopDet) begin
        busy_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Byte engine: address, receive, transmit and acknowledge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= `IEU_RST_BYTE;
      txShift_q <= `IEU_RST_BYTE;
      rxData_q <= `IEU_RST_BYTE;
      srw_q <= 1'b0;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
      stretch_q <= 1'b0;
    end else if (!modEn || startDet || stopDet || rxReset || evClto) begin
      // Timeout or stop releases the bus; start begins a new address
      state_q <= (modEn && startDet) ? ST_ADDR : ST_IDLE;
      bitCnt_q <= startDet ? `IEU_PRE_BIT : 4'h0; // Start fall wraps to 0
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
      stretch_q <= 1'b0;
    end else if (stretch_q) begin
      // Fast acknowledge holds the clock until software picks the answer
      if (wrC1) begin
        sdaOe <= !regWrData[`IEU_C1_NACK];
        sclOe <= 1'b0;
        stretch_q <= 1'b0;
      end
    end else if (sclRise && state_q != ST_IDLE) begin
      shift_q <= {shift_q[6:0], line.sda};
    end else if (sclFall && state_q != ST_IDLE && state_q != ST_SKIP) begin
      if (bitCnt_q == `IEU_LAST_BIT) begin
        bitCnt_q <= `IEU_ACK_BIT;
        rxData_q <= shift_q;
        case (state_q)
          ST_ADDR: begin
            sdaOe <= addrMatch;
            srw_q <= shift_q[0];
            if (!addrMatch) begin
              state_q <= ST_SKIP;
            end
          end
          ST_RX: begin
            sdaOe <= !ctrl1_q[`IEU_C1_NACK];
            if (fast_ack_enable) begin
              sdaOe <= 1'b0;
              sclOe <= 1'b1; // Software decides acknowledge [RQ7]
              stretch_q <= 1'b1;
            end
          end
          default: begin
            sdaOe <= 1'b0; // Let the master acknowledge
          end
        endcase
      end else if (bitCnt_q == `IEU_ACK_BIT) begin
        bitCnt_q <= 4'h0;
        sdaOe <= 1'b0;
        if (state_q == ST_ADDR) begin
          state_q <= srw_q ? ST_TX : ST_RX;
          txShift_q <= {txData_q[6:0], 1'b0};
          sdaOe <= srw_q && !txData_q[7];
        end else if (state_q == ST_TX) begin
          // Master not-acknowledge ends slave transmit
          state_q <= shift_q[0] ? ST_SKIP : ST_TX;
          txShift_q <= {txData_q[6:0], 1'b0};
          sdaOe <= !shift_q[0] && !txData_q[7];
        end
      end else begin
        bitCnt_q <= bitCnt_q + 4'h1;
        if (state_q == ST_TX) begin
          sdaOe <= !txShift_q[7];
          txShift_q <= {txShift_q[6:0], 1'b0};
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Timeout counters; data-low shares the idle period [RQ14]
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt_q <= 32'h0000_0000;
      highCnt_q <= 32'h0000_0000;
      chdlCnt_q <= 32'h0000_0000;
      idle_q <= 1'b0;
    end else begin
      lowCnt_q <= tick(modEn && !line.scl, lowCnt_q, CLK_LOW_CYC);
      highCnt_q <= tick(modEn && line.scl && line.sda, highCnt_q,
                        HIGH_MAX_CYC); // [RQ14]
      chdlCnt_q <= tick(modEn && line.scl && !line.sda, chdlCnt_q,
                        HIGH_MAX_CYC); // [RQ14]
      // Idle flag follows the bus alone, no interrupt path [RQ13]
      idle_q <= modEn && line.scl && line.sda &&
        highCnt_q >= HIGH_MAX_CYC - 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tcf_q <= 1'b0;
      aas_q <= 1'b0;
      arbitration_lost_flag_q <= 1'b0;
      clto_q <= 1'b0;
      chdl_q <= 1'b0;
    end else begin
      // Data access clears transfer done
      tcf_q <= evTcf || (tcf_q && !(rdData ||
        (regWr && regAddr == `IEU_REG_DATA))); // [RQ6]
      // Status write of one clears the address flag
      aas_q <= evAas || (aas_q && !(wrSt && regWrData[`IEU_ST_AAS])); // [RQ8]
      arbitration_lost_flag_q <= evArb ||
        (arbitration_lost_flag_q && !(wrSt && regWrData[`IEU_ST_ARBITRATION_LOST_FLAG])); // [RQ11] [RQ12]
      clto_q <= evClto ||
        (clto_q && !(wrSm && regWrData[`IEU_SM_CLTO])); // [RQ3]
      chdl_q <= evChdl || (chdl_q && !(wrSm && regWrData[`IEU_SM_CHDL]));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Combined pending flag and interrupt, wake request outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irqPend_q <= 1'b0;
      irqReq <= 1'b0;
      wakeupReq <= 1'b0;
    end else begin
      // In low power the match counts only with wake enable [RQ5]
      irqPend_q <= evTcf || evArb || evClto || // [RQ3] [RQ11]
        (evAas && (!lowPowerMode || ctrl1_q[`IEU_C1_WAKEUP_ENABLE])) || // [RQ5]
        (evChdl && ctrl2_q[`IEU_C2_CHDLIE]) || // [RQ4]
        (irqPend_q && !(wrSt && regWrData[`IEU_ST_IRQ])); // [RQ2]
      irqReq <= irqPend_q && irqEn; // [RQ1] [RQ24]
      // Wake lasts in low power until software clears the pending or address flag [RQ10] [RQ17]
      wakeupReq <= lowPowerMode && irqPend_q && irqEn &&
        aas_q && ctrl1_q[`IEU_C1_WAKEUP_ENABLE];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read port, data valid the cycle after the strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= `IEU_RST_BYTE;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sclOut <= 1'b0; // Open drain: only ever pulls low
      sdaOut <= 1'b0;
      regRdData <= `IEU_RST_BYTE;
      if (regRd) begin
        if (regAddr == `IEU_REG_CTRL1) begin
          regRdData <= ctrl1_q;
        end else if (regAddr == `IEU_REG_CTRL2) begin
          regRdData <= ctrl2_q;
        end else if (regAddr == `IEU_REG_STATUS) begin
          regRdData <= {tcf_q, aas_q, busy_q, arbitration_lost_flag_q, 1'b0, srw_q,
                        irqPend_q, 1'b0}; // Direction for software [RQ9]
        end else if (regAddr == `IEU_REG_SMB) begin
          regRdData <= {4'h0, clto_q, idle_q, chdl_q, 1'b0};
        end else if (regAddr == `IEU_REG_ADDR1) begin
          regRdData <= addr1_q;
        end else if (regAddr == `IEU_REG_ADDR2) begin
          regRdData <= addr2_q;
        end else if (regAddr == `IEU_REG_DATA) begin
          regRdData <= rxData_q;
        end else begin
          regRdData <= {4'h0, filt_q};
        end
      end
    end
  end
endmodule : ieu_event_unit

/* File: core/ieu_defines.svh */
// Offsets, field positions, reset values and timing for the event block.
// Assumes a 40 MHz core clock and an 8-bit register port.
`ifndef IEU_DEFINES_SVH
`define IEU_DEFINES_SVH
`define IEU_CLK_MHZ 40
// Register indexes on the 3-bit register port
`define IEU_REG_CTRL1 3'h0
`define IEU_REG_CTRL2 3'h1
`define IEU_REG_STATUS 3'h2
`define IEU_REG_SMB 3'h3
`define IEU_REG_ADDR1 3'h4
`define IEU_REG_ADDR2 3'h5
`define IEU_REG_DATA 3'h6
`define IEU_REG_FILT 3'h7
// Control 1 fields
`define IEU_C1_MODEN 7
`define IEU_C1_IRQEN 6
`define IEU_C1_MST 5
`define IEU_C1_TX 4
`define IEU_C1_NACK 3
`define IEU_C1_RSTA 2
`define IEU_C1_WAKEUP_ENABLE 1
`define IEU_C1_FAST_ACK_ENABLE 0
// Control 2 fields
`define IEU_C2_GCEN 7
`define IEU_C2_ADDR2EN 6
`define IEU_C2_CHDLIE 5
// Status fields
`define IEU_ST_TCF 7
`define IEU_ST_AAS 6
`define IEU_ST_BUSY 5
`define IEU_ST_ARBITRATION_LOST_FLAG 4
`define IEU_ST_SRW 2
`define IEU_ST_IRQ 1
// SMBus flag fields
`define IEU_SM_CLTO 3
`define IEU_SM_IDLE 2
`define IEU_SM_CHDL 1
// Reset values and codes
`define IEU_RST_BYTE 8'h00
`define IEU_GC_ADDR 8'h00
`define IEU_FILT_RST 4'h0
`define IEU_ACK_BIT 4'h8
`define IEU_LAST_BIT 4'h7
`define IEU_PRE_BIT 4'hF
// Bus timeouts in ns
`define IEU_CLK_LOW_NS 35000000
`define IEU_HIGH_MAX_NS 50000
`endif

/* File: core/ieu_pkg.sv */
// Types shared by the event block and its input filter.
// Assumes nothing of its surroundings.
package ieu_pkg;
  // Both bus lines travel together
  typedef struct packed {
    logic scl;
    logic sda;
  } ieu_lines_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_RX = 3'b010,
    ST_TX = 3'b011,
    ST_SKIP = 3'b100
  } ieu_state_e;
endpackage : ieu_pkg

/* File: core/ieu_glitch_filter.sv */
// Two-flop synchroniser and programmable glitch filter for the bus lines.
// Assumes raw pin levels from outside the core clock domain.
`timescale 1ns/1ps
module ieu_glitch_filter
  import ieu_pkg::*;
#(
  parameter int CW = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire ieu_lines_s rawLines,
  input wire logic [CW-1:0] limit,
  output ieu_lines_s cleanLines
);
  ieu_lines_s meta_q;
  ieu_lines_s sync_q;
  logic [CW-1:0] cnt_q [2];

  //////////////////////////////////////////////////////////////////////////
  // Synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '{scl: 1'b1, sda: 1'b1};
      sync_q <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      meta_q <= rawLines;
      sync_q <= meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // A change must outlast the limit before it passes [RQ15]
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cleanLines <= '{scl: 1'b1, sda: 1'b1};
      cnt_q[0] <= '0;
      cnt_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sync_q[i] == cleanLines[i]) begin
          cnt_q[i] <= '0; // Short pulse is dropped here [RQ15]
        end else if (cnt_q[i] >= limit) begin
          cleanLines[i] <= sync_q[i];
          cnt_q[i] <= '0;
        end else begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
        end
      end
    end
  end
endmodule : ieu_glitch_filter

/* File: verif/ieu_event_asserts.sv */
// Concurrent checks on the event unit's ports.
// Assumes one core clock domain; control bits shadowed from writes.
`timescale 1ns/1ps
`include "ieu_defines.svh"
module ieu_event_asserts #(
  parameter int unsigned CLK_LOW_CYC = 200,
  parameter int unsigned HIGH_MAX_CYC = 50
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic sclIn,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic lowPowerMode,
  input wire logic irqReq,
  input wire logic wakeupReq
);
  logic [7:0] shadow_q;
  logic c1Wr, clrIrq, irqOff, irqEn, modEn, wakeup_enable, fackEn;
  // Decoded writes and shadowed enables
  assign c1Wr = regWr && regAddr == `IEU_REG_CTRL1;
  assign clrIrq = regWr && regAddr == `IEU_REG_STATUS && regWrData[1];
  assign irqOff = c1Wr && !regWrData[`IEU_C1_IRQEN];
  assign irqEn = shadow_q[`IEU_C1_IRQEN];
  assign modEn = shadow_q[`IEU_C1_MODEN];
  assign wakeup_enable = shadow_q[`IEU_C1_WAKEUP_ENABLE];
  assign fackEn = shadow_q[`IEU_C1_FAST_ACK_ENABLE];
  // Copy of control 1, cleared by reset like the unit's own
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shadow_q <= 8'h00;
    end else if (c1Wr) begin
      shadow_q <= regWrData;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  irq_masked_a: assert property (
    !irqEn && !$past(irqEn) |-> !irqReq) else $error("irq while masked");
  irq_clear_a: assert property (
    $fell(irqReq) |-> $past(clrIrq, 2) || $past(irqOff, 2))
    else $error("irq dropped without clear");
  rd_idle_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside its slot");
  wake_gate_a: assert property (
    wakeupReq |-> $past(lowPowerMode) && $past(irqEn) && $past(wakeup_enable))
    else $error("wake without its enables");
  off_quiet_a: assert property (
    !modEn && !$past(modEn) |-> !sdaOe && !sclOe)
    else $error("disabled unit drives the bus");
  ack_edge_a: assert property ($changed(sdaOe) |-> !$past(sclIn))
    else $error("data moved while clock high");
  stretch_set_a: assert property (
    $rose(sclOe) |-> $past(fackEn) && !$past(sclIn))
    else $error("stretch without fast ack");
  stretch_hold_a: assert property (sclOe && !c1Wr |=> sclOe)
    else $error("stretch released early");
  cover property ($rose(irqReq));
  cover property ($rose(wakeupReq));
  cover property ($rose(sclOe));
endmodule : ieu_event_asserts
////////////////////////////////////////////////////////////
bind ieu_event_unit ieu_event_asserts #(
  .CLK_LOW_CYC(CLK_LOW_CYC),
  .HIGH_MAX_CYC(HIGH_MAX_CYC)
) ieu_event_asserts_inst (.core_clk, .resetn, .regAddr, .regWrData,
  .regWr, .regRd, .regRdData, .sclIn, .sclOe, .sdaOe, .lowPowerMode,
  .irqReq, .wakeupReq);

/* File: verif/ieu_bus_master.sv */
// Behavioural two-wire bus master facing the event unit.
// Assumes pull-ups on both lines and a 200 ns bus clock.
`timescale 1ns/1ps
module ieu_bus_master (
  input wire logic sclOe,
  input wire logic sdaOe,
  output logic sclLine,
  output logic sdaLine
);
  logic mScl = 1'b1;
  logic mSda = 1'b1;
  // Wired AND: a released line floats high
  assign sclLine = mScl & ~sclOe;
  assign sdaLine = mSda & ~sdaOe;
  // Hold both lines for a time; clock stands still between frames
  task automatic drive(input logic s, input logic d, input int ns);
    mScl = s;
    mSda = d;
    #(ns);
  endtask : drive
  task automatic startCond();
    drive(1'b1, 1'b1, 100);
    drive(1'b1, 1'b0, 100);
    drive(1'b0, 1'b0, 100);
  endtask : startCond
  task automatic stopCond();
    drive(1'b0, 1'b0, 100);
    drive(1'b1, 1'b0, 100);
    drive(1'b1, 1'b1, 100);
  endtask : stopCond
  // High phase waits out a slave stretch, bounded so a stuck line ends
  task automatic bitCycle(input logic b, output logic s);
    int n;
    drive(1'b0, b, 100);
    mScl = 1'b1;
    n = 0;
    while (!sclLine && n < 400) begin
      #25;
      n++;
    end
    #100;
    s = sdaLine;
    mScl = 1'b0;
  endtask : bitCycle
  // Byte MSB first, then the acknowledge slot with data released
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(b[i], s);
    end
    bitCycle(1'b1, ack);
  endtask : sendByte
endmodule : ieu_bus_master

/* File: verif/tb_top.sv */
// Self-checking bench for the event unit and a bus master model.
// Assumes defines, package, unit, filter and master model built first.
`timescale 1ns/1ps
`include "ieu_defines.svh"
module tb_top;
  localparam int unsigned CLO = 200;
  localparam int unsigned HMX = 50;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic lowPowerMode = 1'b0;
  logic [7:0] regRdData;
  logic sclLine, sdaLine, sclOe, sdaOe, irqReq, wakeupReq, ack;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  // Short timeouts keep the run brief
  ieu_event_unit #(.CLK_LOW_CYC(CLO), .HIGH_MAX_CYC(HMX)) ieu_event_unit_inst (
    .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .sclIn(sclLine), .sdaIn(sdaLine),
    .sclOut(), .sclOe(sclOe), .sdaOut(), .sdaOe(sdaOe),
    .lowPowerMode(lowPowerMode), .irqReq(irqReq), .wakeupReq(wakeupReq));
  ieu_bus_master ieu_bus_master_inst (.sclOe(sclOe), .sdaOe(sdaOe),
    .sclLine(sclLine), .sdaLine(sdaLine));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // Hang guard well above the expected thousand or so cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : regWrite
  // Data stands only in the cycle after the strobe
  task automatic regChk(input logic [2:0] a, input logic [7:0] m,
                        input logic [7:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData & m, e);
  endtask : regChk
  task automatic waitCyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : waitCyc
  ////////////////////////////////////////////////////////////
  task automatic tAddr();
    regChk(`IEU_REG_CTRL1, 8'hFF, 8'h00);
    regWrite(`IEU_REG_ADDR1, 8'h5A);
    regWrite(`IEU_REG_CTRL1, 8'hC0);
    ieu_bus_master_inst.startCond();
    fork
      ieu_bus_master_inst.sendByte(8'h5A, ack);
      begin
        for (int i = 0; i < 200 && !sdaOe; i++) waitCyc(1);
        regChk(`IEU_REG_STATUS, 8'hC0, 8'h40);
      end
    join
    chk(8'(ack), 8'h00);
    waitCyc(6);
    regChk(`IEU_REG_STATUS, 8'hC6, 8'hC2);
    chk(8'(irqReq), 8'h01);
    regWrite(`IEU_REG_STATUS, 8'h00);
    regChk(`IEU_REG_STATUS, 8'h02, 8'h02);
    regChk(`IEU_REG_DATA, 8'hFF, 8'h5A);
    regWrite(`IEU_REG_STATUS, 8'h42);
    waitCyc(2);
    chk(8'(irqReq), 8'h00);
    // Data byte with fast ack: unit stretches and waits for software
    regWrite(`IEU_REG_CTRL1, 8'hC1);
    fork
      ieu_bus_master_inst.sendByte(8'h3C, ack);
      begin
        for (int i = 0; i < 200 && !sclOe; i++) waitCyc(1);
        regChk(`IEU_REG_STATUS, 8'h80, 8'h80);
        regWrite(`IEU_REG_CTRL1, 8'hC0);
      end
    join
    chk(8'(ack), 8'h00);
    regChk(`IEU_REG_DATA, 8'hFF, 8'h3C);
    ieu_bus_master_inst.stopCond();
    regWrite(`IEU_REG_STATUS, 8'h52);
  endtask : tAddr
  // General call ignored, then answered; pending stays masked
  task automatic tGenCall();
    regWrite(`IEU_REG_CTRL1, 8'h80);
    for (int g = 0; g < 2; g++) begin
      regWrite(`IEU_REG_CTRL2, g ? 8'h80 : 8'h00);
      ieu_bus_master_inst.startCond();
      ieu_bus_master_inst.sendByte(`IEU_GC_ADDR, ack);
      ieu_bus_master_inst.stopCond();
      chk(8'(ack), 8'(g == 0));
    end
    regChk(`IEU_REG_STATUS, 8'h02, 8'h02);
    chk(8'(irqReq), 8'h00);
    regChk(`IEU_REG_DATA, 8'hFF, `IEU_GC_ADDR);
    regWrite(`IEU_REG_STATUS, 8'h52);
  endtask : tGenCall
  task automatic tArb();
    regWrite(`IEU_REG_CTRL1, 8'hC4);
    regChk(`IEU_REG_STATUS, 8'h12, 8'h12);
    chk(8'(irqReq), 8'h01);
    regWrite(`IEU_REG_STATUS, 8'h02);
    regChk(`IEU_REG_STATUS, 8'h10, 8'h10);
    regWrite(`IEU_REG_STATUS, 8'h10);
    regChk(`IEU_REG_STATUS, 8'h12, 8'h00);
    regWrite(`IEU_REG_CTRL1, 8'hF0);
    regChk(`IEU_REG_STATUS, 8'h10, 8'h00);
  endtask : tArb
  task automatic tTimeout();
    regWrite(`IEU_REG_CTRL1, 8'hC0);
    ieu_bus_master_inst.drive(1'b0, 1'b1, (CLO + 20) * 25);
    regChk(`IEU_REG_SMB, 8'h08, 8'h08);
    chk(8'(irqReq), 8'h01);
    regWrite(`IEU_REG_SMB, 8'h08);
    regWrite(`IEU_REG_STATUS, 8'h02);
    regChk(`IEU_REG_SMB, 8'h08, 8'h00);
    ieu_bus_master_inst.drive(1'b1, 1'b0, (HMX - 15) * 25);
    regChk(`IEU_REG_SMB, 8'h02, 8'h00);
    ieu_bus_master_inst.drive(1'b1, 1'b0, 40 * 25);
    regChk(`IEU_REG_SMB, 8'h02, 8'h02);
    regChk(`IEU_REG_STATUS, 8'h02, 8'h00);
    ieu_bus_master_inst.drive(1'b1, 1'b1, (HMX + 20) * 25);
    regChk(`IEU_REG_SMB, 8'h04, 8'h04);
    regChk(`IEU_REG_STATUS, 8'h02, 8'h00);
    // Short glitch is swallowed, a long low drops the idle flag
    regWrite(`IEU_REG_FILT, 8'h08);
    ieu_bus_master_inst.drive(1'b1, 1'b0, 75);
    ieu_bus_master_inst.drive(1'b1, 1'b1, 50);
    regChk(`IEU_REG_SMB, 8'h04, 8'h04);
    ieu_bus_master_inst.drive(1'b1, 1'b0, 20 * 25);
    regChk(`IEU_REG_SMB, 8'h04, 8'h00);
    regWrite(`IEU_REG_FILT, 8'h00);
    regWrite(`IEU_REG_CTRL2, 8'h20);
    regWrite(`IEU_REG_SMB, 8'h02);
    ieu_bus_master_inst.drive(1'b1, 1'b0, (HMX + 20) * 25);
    regChk(`IEU_REG_STATUS, 8'h02, 8'h02);
    ieu_bus_master_inst.drive(1'b1, 1'b1, 100);
    regWrite(`IEU_REG_SMB, 8'h0A);
    regWrite(`IEU_REG_STATUS, 8'h52);
  endtask : tTimeout
  // Address match while asleep raises the wake request
  task automatic tWake();
    regWrite(`IEU_REG_CTRL1, 8'hC2);
    lowPowerMode <= 1'b1;
    ieu_bus_master_inst.startCond();
    ieu_bus_master_inst.sendByte(8'h5A, ack);
    waitCyc(6);
    chk(8'(ack), 8'h00);
    chk(8'(wakeupReq), 8'h01);
    @(posedge core_clk);
    lowPowerMode <= 1'b0;
    regWrite(`IEU_REG_STATUS, 8'h42);
    ieu_bus_master_inst.stopCond();
    chk(8'(wakeupReq), 8'h00);
  endtask : tWake
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    chk(8'(irqReq), 8'h00);
    tAddr();
    tGenCall();
    tArb();
    tTimeout();
    tWake();
    tally_and_finish();
  end
endmodule : tb_top
